// File: pkg/scmr_consts.svh
// Constants of the serial configuration memory read-out block
`ifndef SCMR_CONSTS_SVH
`define SCMR_CONSTS_SVH

// Stored bits and address width
`define SCMR_BITS 1048576
`define SCMR_AW 20

// Power-up reset length in clock cycles
`define SCMR_POR_CYCLES 16

// Pin synchroniser bit positions
`define SCMR_PIN_CLK 0
`define SCMR_PIN_CE_N 1
`define SCMR_PIN_RSTOE 2
`define SCMR_PIN_PROG_N 3
`define SCMR_PIN_WP1 4
`define SCMR_PIN_WP2 5
`define SCMR_PIN_DSEL 6
`define SCMR_PIN_DATA 7
`define SCMR_PIN_N 8

// Synchroniser reset values: standby, reset level, read-out mode
`define SCMR_PIN_RST 8'h0a

// Polarity bytes that invert the reset input
`define SCMR_POL_INVERT 32'h00000000

`endif

// File: pkg/scmr_pkg.sv
// Types of the serial configuration memory read-out block
package scmr_pkg;

  // Device state, Gray coded along POR, standby, read, done
  typedef enum logic [2:0] {
    SCMR_POR = 3'h0,
    SCMR_STBY = 3'h1,
    SCMR_READ = 3'h3,
    SCMR_DONE = 3'h2,
    SCMR_PROG = 3'h6
  } scmr_state_t;

endpackage

// File: pkg/scmr_ctr_if.sv
// Link between the top and its address counter
`timescale 1ns/1ns
`default_nettype none

interface scmr_ctr_if #(
  parameter int AW = 20
);
  logic clear; // Synchronous clear of address and done
  logic step; // Advance by one bit
  logic [AW-1:0] addr; // Current bit address
  logic done; // All bits have been stepped out

  modport ctr (input clear, input step, output addr, output done);
  modport user (output clear, output step, input addr, input done);
endinterface

`default_nettype wire

// File: hw/scmr_ctr.sv
// Address and bit counter with end-of-memory flag
`timescale 1ns/1ns
`default_nettype none

module scmr_ctr #(
  parameter int AW = 20
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  scmr_ctr_if.ctr bus
);

  // Highest address of the array
  localparam logic [AW-1:0] LAST = {AW{1'b1}};

  // Counter is the address; its low three bits are the bit counter
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bus.addr <= '0;
      bus.done <= 1'b0;
    end
    else if (bus.clear)
    begin
      bus.addr <= '0;
      bus.done <= 1'b0;
    end
    else if (bus.step && !bus.done)
    begin
      // Last bit sets done and holds, so no wrap back to zero
      if (bus.addr == LAST)
        bus.done <= 1'b1;
      else
        bus.addr <= bus.addr + 1'b1;
    end
  end

  // Done only rises from a step at the last address
  a_done_cause: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    $rose(bus.done) |-> $past(bus.step && bus.addr == LAST))
    else $error("done rose without a last step");

endmodule

`default_nettype wire

// File: hw/scmr_top.sv
// Serial configuration memory: read-out, cascade and standby logic
//
// Function
// - Reset level clears counters outside programming, floats data.
// - Drive data only with output enable, chip enable.
// - Counter advances only when enabled.
// - Chip enable high freezes counters, standby.
// - Programming mode ignores chip enable.
// - Cascade output low after last bit.
// - Cascade tracks chip enable until reset.
// - Float data once memory fully read.
// - Reset level floats data regardless of enable.
// - Power-up clears the address counter.
// - Ready pulled low during power-up reset.
// - Each enabled host clock rising edge steps the counters.
// - Four polarity bytes select reset polarity.
// - Write protect only guards programming.
// - Device select only acts when programming.
// - Data tri-state reading, never driven when programming.
// - Chained device drives when enabled.
// - Standby keeps data floating always.
`timescale 1ns/1ns
`default_nettype none
`include "scmr_consts.svh"

module scmr_top #(
  parameter int BITS = `SCMR_BITS, // Stored bits
  parameter int AW = `SCMR_AW, // Address width
  parameter int POR_CYCLES = `SCMR_POR_CYCLES // Up to 255
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_config_clock,
  input wire logic i_chip_enable_n,
  input wire logic i_reset_oe,
  input wire logic i_program_mode_select_n,
  input wire logic i_write_protect_one,
  input wire logic i_write_protect_two,
  input wire logic i_device_select_pin,
  input wire logic [31:0] i_polarity_bytes,
  input wire logic i_data_in,
  output logic o_data_out,
  output logic o_data_oe,
  output logic o_cascade_enable_out_n,
  output logic o_ready_out,
  output logic o_ready_oe
);

  // Raw pins gathered for one synchroniser loop
  wire [`SCMR_PIN_N-1:0] pins_raw;
  // Reset value of each synchroniser bit
  localparam logic [`SCMR_PIN_N-1:0] PIN_RST = `SCMR_PIN_RST;

  assign pins_raw[`SCMR_PIN_CLK] = i_config_clock;
  assign pins_raw[`SCMR_PIN_CE_N] = i_chip_enable_n;
  assign pins_raw[`SCMR_PIN_RSTOE] = i_reset_oe;
  assign pins_raw[`SCMR_PIN_PROG_N] = i_program_mode_select_n;
  assign pins_raw[`SCMR_PIN_WP1] = i_write_protect_one;
  assign pins_raw[`SCMR_PIN_WP2] = i_write_protect_two;
  assign pins_raw[`SCMR_PIN_DSEL] = i_device_select_pin;
  assign pins_raw[`SCMR_PIN_DATA] = i_data_in;

  // First and second synchroniser stages
  logic [`SCMR_PIN_N-1:0] pin_s1_r;
  logic [`SCMR_PIN_N-1:0] pin_s2_r;

  // Two flops per pin; only the second stage is read by logic
  genvar gi;
  generate
    for (gi = 0; gi < `SCMR_PIN_N; gi++)
    begin : g_sync
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          pin_s1_r[gi] <= PIN_RST[gi];
          pin_s2_r[gi] <= PIN_RST[gi];
        end
        else
        begin
          pin_s1_r[gi] <= pins_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
        end
      end
    end
  endgenerate

  // Polarity bytes, a static strap, also pass two flops
  logic [31:0] pol_s1_r;
  logic [31:0] pol_s2_r;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pol_s1_r <= 32'hffffffff;
      pol_s2_r <= 32'hffffffff;
    end
    else
    begin
      pol_s1_r <= i_polarity_bytes;
      pol_s2_r <= pol_s1_r;
    end
  end

  // Delayed host clock for edge detection
  logic config_clock_d_r;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      config_clock_d_r <= 1'b0;
    else
      config_clock_d_r <= pin_s2_r[`SCMR_PIN_CLK];
  end

  // Decoded pin levels
  wire clk_rise;
  wire ce_n;
  wire pol_inv;
  wire rst_lvl;
  wire oe_act;
  wire prog;
  wire dsel;
  wire prot_hit;
  wire read_en;
  wire prog_step;

  // Rising edge of the host clock
  assign clk_rise = pin_s2_r[`SCMR_PIN_CLK] & ~config_clock_d_r;
  assign ce_n = pin_s2_r[`SCMR_PIN_CE_N];
  // Default: low is reset, high is output enable
  assign pol_inv = (pol_s2_r == `SCMR_POL_INVERT);
  assign rst_lvl = pin_s2_r[`SCMR_PIN_RSTOE] ^ ~pol_inv;
  assign oe_act = ~rst_lvl;
  // Mode select low means programming; host keeps it high to load
  assign prog = ~pin_s2_r[`SCMR_PIN_PROG_N];
  // Device select has no say outside programming
  assign dsel = prog & pin_s2_r[`SCMR_PIN_DSEL];

  // Counter link
  scmr_ctr_if #(.AW(AW)) ctr ();

  // Read-out needs enable, chip enable and bits left
  assign read_en = ~prog & oe_act & ~ce_n & ~ctr.done;
  // Programming steps on every clock while device select is high; chip enable plays no part
  assign prog_step = clk_rise & dsel;

  // Lower half guarded by one protect pin, upper by the other
  assign prot_hit = ctr.addr[AW-1] ? pin_s2_r[`SCMR_PIN_WP2]
                                   : pin_s2_r[`SCMR_PIN_WP1];

  // State register and power-up counter
  scmr_pkg::scmr_state_t state_r;
  scmr_pkg::scmr_state_t state_nxt;
  logic [7:0] por_cnt_r;
  wire por_end;
  wire prog_entry;

  assign por_end = (por_cnt_r == 8'h00);
  assign prog_entry = prog & (state_r != scmr_pkg::SCMR_PROG);

  // Next state: power-up first, then programming, reset, done
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      scmr_pkg::SCMR_POR:
        if (por_end)
          state_nxt = scmr_pkg::SCMR_STBY;
      scmr_pkg::SCMR_STBY,
      scmr_pkg::SCMR_READ,
      scmr_pkg::SCMR_DONE,
      scmr_pkg::SCMR_PROG:
        if (prog)
          state_nxt = scmr_pkg::SCMR_PROG;
        else if (rst_lvl)
          state_nxt = scmr_pkg::SCMR_STBY;
        else if (ctr.done)
          state_nxt = scmr_pkg::SCMR_DONE;
        else if (ce_n)
          state_nxt = scmr_pkg::SCMR_STBY;
        else
          state_nxt = scmr_pkg::SCMR_READ;
      default:
        state_nxt = scmr_pkg::SCMR_POR;
    endcase
  end

  // State and power-up countdown
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= scmr_pkg::SCMR_POR;
      por_cnt_r <= 8'(POR_CYCLES - 1);
    end
    else
    begin
      state_r <= state_nxt;
      if (!por_end)
        por_cnt_r <= por_cnt_r - 8'h01;
    end
  end

  wire in_por;
  assign in_por = (state_r == scmr_pkg::SCMR_POR);

  // Clear during power-up, on reset level outside programming, and on entry to programming
  assign ctr.clear = in_por | (~prog & rst_lvl) | prog_entry;
  // Counters move only on a host clock edge, frozen in standby
  assign ctr.step = ~in_por & clk_rise & (read_en | dsel);

  scmr_ctr #(.AW(AW)) u_ctr (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(ctr)
  );

  // Stored bits; contents are not cleared by reset, as in the array
  logic mem [BITS];

  // Programming writes the sampled data pin unless protected
  always_ff @(posedge i_clk)
  begin
    if (!in_por && prog_step && !prot_hit)
      mem[ctr.addr] <= pin_s2_r[`SCMR_PIN_DATA];
  end

  // Output flops
  logic data_r;
  logic data_oe_r;
  logic ceo_n_r;
  logic ready_oe_r;

  // Bit at the current address; address zero after any clear
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      data_r <= 1'b0;
    else
      data_r <= mem[ctr.addr];
  end

  // Drive only while reading; programming never drives the pin
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      data_oe_r <= 1'b0;
    else
      data_oe_r <= ~in_por & read_en;
  end

  // Cascade low when done, chip enable low, output enable active
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ceo_n_r <= 1'b1;
    else
      ceo_n_r <= ~(ctr.done & ~ce_n & oe_act & ~prog);
  end

  // Ready pin pulled low while the power-up reset lasts
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ready_oe_r <= 1'b1;
    else
      ready_oe_r <= (state_nxt == scmr_pkg::SCMR_POR);
  end

  assign o_data_out = data_r;
  assign o_data_oe = data_oe_r;
  assign o_cascade_enable_out_n = ceo_n_r;
  // Open collector: only ever pulls low
  assign o_ready_out = 1'b0;
  assign o_ready_oe = ready_oe_r;

  // Checks of the visible behaviour
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  localparam logic [AW-1:0] LAST = {AW{1'b1}};

  // A read step on the last address
  sequence s_last_step;
    ctr.step && read_en && ctr.addr == LAST;
  endsequence

  // Done follows, then cascade falls while still enabled
  sequence s_cascade_fall;
    ctr.done ##1 (!o_cascade_enable_out_n || !oe_act || ce_n || prog);
  endsequence

  a_reset_clears: assert property (
    !in_por && !prog && rst_lvl |=> ctr.addr == '0 && !ctr.done)
    else $error("reset level did not clear counter");

  a_drive_gate: assert property (
    o_data_oe |-> $past(oe_act && !ce_n && !prog))
    else $error("data driven without enables");

  a_step_cause: assert property (
    !prog && ctr.addr != $past(ctr.addr) && ctr.addr != '0
    |-> $past(clk_rise && read_en))
    else $error("address moved without enabled clock");

  a_standby_hold: assert property (
    !prog && !rst_lvl && ce_n && !in_por |=> $stable(ctr.addr))
    else $error("counter moved in standby");

  a_prog_step: assert property (
    !in_por && !prog_entry && prog_step && !ctr.done
    && ctr.addr != LAST |=> ctr.addr == $past(ctr.addr) + 1'b1)
    else $error("programming clock did not step");

  a_cascade_low: assert property (
    s_last_step |=> s_cascade_fall)
    else $error("cascade did not fall after last bit");

  a_done_float: assert property (
    ctr.done |=> !o_data_oe)
    else $error("data driven after last bit");

  a_standby_float: assert property (
    ce_n && !prog |=> !o_data_oe)
    else $error("data driven in standby");

  a_ready_por: assert property (
    in_por |-> o_ready_oe ##0 ctr.addr == '0)
    else $error("ready released during power-up");

  a_ceo_track: assert property (
    ctr.done && oe_act && !prog |=> o_cascade_enable_out_n == $past(ce_n))
    else $error("cascade did not track chip enable");

endmodule

`default_nettype wire

// File: sim/scmr_host_model.sv
// Host model: master-serial loader driving clock, enables and data pin
`timescale 1ns/1ns
`default_nettype none

module scmr_host_model (
  input wire logic i_clk,
  input wire logic i_pin,
  input wire logic i_pin_oe,
  output logic o_config_clock,
  output logic o_ce_n,
  output logic o_reset_oe,
  output logic o_mode_n,
  output logic o_din
);
  logic last = 1'b0; // Last level seen on the data pin

  // Power-on pin levels: standby, reset level, loading mode
  initial
  begin
    o_config_clock <= 1'b0;
    o_ce_n <= 1'b1;
    o_reset_oe <= 1'b0;
    o_mode_n <= 1'b1; // Loading keeps programming off
    o_din <= 1'b0;
  end

  // Move control pins, then give the pin synchronisers time to settle
  task automatic pins(input logic ce_n, input logic roe, input logic mode_n);
    @(posedge i_clk);
    o_ce_n <= ce_n;
    o_reset_oe <= roe;
    o_mode_n <= mode_n;
    repeat (6) @(posedge i_clk);
  endtask

  // One host clock, 4 cycles high and 4 low; sample after the step
  task automatic tick(input logic din, output logic b);
    @(posedge i_clk);
    o_din <= din;
    @(posedge i_clk);
    o_config_clock <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_config_clock <= 1'b0;
    repeat (4) @(posedge i_clk);
    // A released pin holds no value, so report the inverse
    b = i_pin_oe ? i_pin : ~last;
    last = b;
  endtask
endmodule

`default_nettype wire

// File: sim/test_serial_config_memory_readout.sv
// Self-checking bench for the serial configuration memory read-out
`timescale 1ns/1ns
`default_nettype none

module test_serial_config_memory_readout;
  localparam int BITS = 16; // Short memory keeps the run brief
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic wp1 = 1'b0;
  logic wp2 = 1'b0; // Guards the upper half while programming
  logic dsel = 1'b1;
  logic [31:0] pol = 32'h00000001; // Non-zero keeps default polarity
  wire logic config_clock, ce_n, roe, mode_n, din, dout, doe, ceo_n, rdy, rdy_oe;
  wire logic pin;
  wire logic ready_pin;
  int n_mismatch = 0;
  int n_checks = 0;
  logic b;
  logic [15:0] word;
  logic [15:0] img = 16'hc3a5; // Image loaded into the array

  assign pin = doe ? dout : din; // Device or host owns the data pin
  assign ready_pin = rdy_oe ? rdy : 1'b1; // Board pull-up on ready

  always #10 i_clk = ~i_clk;

  scmr_top #(.BITS(BITS), .AW(4), .POR_CYCLES(2)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_config_clock(config_clock),
    .i_chip_enable_n(ce_n), .i_reset_oe(roe),
    .i_program_mode_select_n(mode_n), .i_write_protect_one(wp1),
    .i_write_protect_two(wp2), .i_device_select_pin(dsel),
    .i_polarity_bytes(pol), .i_data_in(pin), .o_data_out(dout),
    .o_data_oe(doe), .o_cascade_enable_out_n(ceo_n),
    .o_ready_out(rdy), .o_ready_oe(rdy_oe));

  scmr_host_model host (
    .i_clk(i_clk), .i_pin(pin), .i_pin_oe(doe), .o_config_clock(config_clock),
    .o_ce_n(ce_n), .o_reset_oe(roe), .o_mode_n(mode_n), .o_din(din));

  // Compare and count; report a mismatch at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Print the verdict and end the run
  task automatic finish_test;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Write a whole image serially; a low chip enable also sets output enable
  task automatic prog(input logic [15:0] w, input logic ce_lvl);
    host.pins(ce_lvl, ~ce_lvl, 1'b0); // Chip enable has no say
    for (int i = 0; i < BITS; i++)
      host.tick(w[i], b); // Each selected clock steps, and writes unless protected
    chk(doe, 1'b0); // Pin never driven while programming
    host.pins(1'b1, 1'b0, 1'b1);
  endtask

  // Full read-out with a standby pause in mid-stream
  task automatic rd_all(output logic [15:0] w);
    host.pins(1'b1, 1'b0, 1'b1); // Reset level clears the counter
    host.pins(1'b1, 1'b1, 1'b1);
    chk(doe, 1'b0); // Standby keeps the pin floating
    host.pins(1'b0, 1'b1, 1'b1);
    chk(doe, 1'b1); // Enabled read drives the pin
    w[0] = pin;
    for (int i = 1; i < BITS; i++)
    begin
      // Clocks in standby must not step the counter
      if (i == 8)
      begin
        host.pins(1'b1, 1'b1, 1'b1);
        host.tick(1'b0, b); // Frozen counter
        host.pins(1'b0, 1'b1, 1'b1);
      end
      host.tick(1'b0, b);
      w[i] = b;
    end
    chk(ceo_n, 1'b1); // Last bit not yet stepped past
    host.tick(1'b0, b);
    chk({ceo_n, doe}, 2'b00); // Cascade low, pin released
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge i_clk);
    chk({ready_pin, doe}, 2'b00); // Power-up: ready low, pin off
    i_rst_n <= 1'b1;
    repeat (10) @(posedge i_clk);
    chk(ready_pin, 1'b1); // Ready released after power-up
    prog(img, 1'b1); // Chip enable high: no disabling
    dsel <= 1'b0;
    prog(~img, 1'b1); // Not selected: must be ignored
    rd_all(word);
    chk(word, img); // Ascending from address zero
    host.pins(1'b1, 1'b1, 1'b1);
    chk(ceo_n, 1'b1); // Cascade follows chip enable
    host.pins(1'b0, 1'b1, 1'b1);
    chk(ceo_n, 1'b0); // Cascade low again
    host.tick(1'b0, b);
    chk(doe, 1'b0); // Clocks after the end keep the pin off
    host.pins(1'b0, 1'b0, 1'b1);
    chk({ceo_n, doe}, 2'b10); // Reset level: cascade high, float
    host.pins(1'b0, 1'b1, 1'b1);
    chk({ceo_n, doe, pin}, {2'b11, img[0]}); // Counter at zero
    host.tick(1'b0, b);
    chk(pin, img[1]); // One bit per clock
    i_rst_n <= 1'b0;
    @(posedge i_clk);
    chk(ready_pin, 1'b0); // Ready low in power-up reset
    i_rst_n <= 1'b1;
    repeat (12) @(posedge i_clk);
    chk({doe, pin}, {1'b1, img[0]}); // Power-up clears the counter
    dsel <= 1'b1;
    wp1 <= 1'b1;
    prog(~img, 1'b0); // Chip enable low: no read drive
    rd_all(word);
    chk(word, {~img[15:8], img[7:0]}); // Lower half guarded
    wp1 <= 1'b0;
    wp2 <= 1'b1;
    prog(16'h0000, 1'b0); // Only the lower half may change
    rd_all(word);
    chk(word, {~img[15:8], 8'h00}); // Upper half guarded
    pol <= 32'h00000000;
    host.pins(1'b0, 1'b1, 1'b1);
    chk({ceo_n, doe}, 2'b10); // Inverted: high level now resets
    host.pins(1'b0, 1'b0, 1'b1);
    chk({doe, pin}, 2'b10); // Inverted: low level enables, bit 0
    finish_test;
  end

  // Watchdog: the sequence needs well under 5000 cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    finish_test;
  end
endmodule

`default_nettype wire
